// ---- logic/fam_ctrl.sv ----
// Top: acoustic ramp, tach gating and floor duty selection with Avalon slave
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ns
module fam_ctrl
    import fam_pkg::*;
#(
    parameter longint SHORT_SLOT = FAM_SHORT_SLOT_CYC,
    parameter longint LONG_SLOT  = FAM_LONG_SLOT_CYC
)(
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    input  wire logic [9:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    output logic      [1:0]  o_avs_response,
    input  wire logic [7:0]  i_target_duty1,
    input  wire logic [7:0]  i_target_duty2,
    input  wire logic [7:0]  i_target_duty3,
    input  wire logic [2:0]  i_below_floor,
    input  wire logic        i_fan_drive_output_3_on,
    input  wire logic        i_fan_tach_input_2,
    input  wire logic        i_fan_tach_input_3,
    input  wire logic        i_fan_tach_input_4,
    output logic      [7:0]  o_fan_drive_output_1,
    output logic      [7:0]  o_fan_drive_output_2,
    output logic      [7:0]  o_fan_drive_output_3,
    output logic      [2:0]  o_tach_gated,
    output logic      [2:0]  o_tach_valid
);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACK  = 3'b010,
        ST_DONE = 3'b100
    } fam_bus_st_t;

    typedef struct packed {
        fam_regs_t   regs;
        fam_bus_st_t bus;
        logic [31:0] rdata;
        logic        err;
        logic [2:0]  tach_s1;
        logic [2:0]  tach_s2;
        logic [1:0]  drv3_s;
        fam_duty_t   out;
    } fam_state_t;

    fam_state_t st_q;
    fam_state_t st_d;
    fam_duty_t  ramped;
    logic [7:0] raw1;
    logic       drv3_on;
    logic       lo_en;
    logic       hit_acou;
    logic       hit_cfg6;
    logic       hit_lock;
    logic       hit_fan;
    logic       hit_stat;

    // Only remote-one driven output 1 is ramped here; others follow directly
    fam_ramp #(
        .SHORT_SLOT (SHORT_SLOT),
        .LONG_SLOT  (LONG_SLOT)
    ) u_ramp1 (
        .i_clock      (i_clock),
        .i_rstn       (i_rstn),
        .i_smooth     (st_q.regs.acoustic2[FAM_SMOOTH_BIT]),
        .i_long_table (st_q.regs.config6[FAM_LONG_TABLE_BIT]),
        .i_slow       (st_q.regs.config6[FAM_SLOW_R1_BIT]),
        .i_rate       (st_q.regs.acoustic2[FAM_RATE_LSB +: 3]),
        .i_target     (raw1),
        .o_duty       (ramped.duty1)
    );

    assign raw1         = i_target_duty1;
    assign ramped.duty2 = i_target_duty2;
    assign ramped.duty3 = i_target_duty3;
    assign lo_en        = i_avs_byteenable[0];

    // Address decode, shared by the read half and the write half
    always_comb
    begin
        hit_acou = 1'b0;
        hit_cfg6 = 1'b0;
        hit_lock = 1'b0;
        hit_fan  = 1'b0;
        hit_stat = 1'b0;
        if (i_avs_address == FAM_ADDR_ACOUSTIC2)
        begin
            hit_acou = 1'b1;
        end
        else if (i_avs_address == FAM_ADDR_CONFIG6)
        begin
            hit_cfg6 = 1'b1;
        end
        else if (i_avs_address == FAM_ADDR_LOCK)
        begin
            hit_lock = 1'b1;
        end
        else if (i_avs_address == FAM_ADDR_FAN_CTRL)
        begin
            hit_fan = 1'b1;
        end
        else if (i_avs_address == FAM_ADDR_STATUS)
        begin
            hit_stat = 1'b1;
        end
    end

    always_comb
    begin
        st_d = st_q;
        // Two-stage synchronisers on the tach and drive-level pins
        st_d.tach_s1   = {i_fan_tach_input_4, i_fan_tach_input_3,
                          i_fan_tach_input_2};
        st_d.tach_s2   = st_q.tach_s1;
        st_d.drv3_s    = {st_q.drv3_s[0], i_fan_drive_output_3_on};
        drv3_on        = st_q.drv3_s[1];

        // Floor handling: off or minimum duty below threshold
        st_d.out.duty1 = ramped.duty1;
        st_d.out.duty2 = ramped.duty2;
        st_d.out.duty3 = ramped.duty3;
        if (st_q.regs.auto_mode && i_below_floor[0])
        begin
            st_d.out.duty1 = st_q.regs.acoustic2[FAM_FLOOR1_BIT]
                             ? st_q.regs.min_duty1 : FAM_DUTY_ZERO;
        end
        if (st_q.regs.auto_mode && i_below_floor[1])
        begin
            st_d.out.duty2 = st_q.regs.acoustic2[FAM_FLOOR2_BIT]
                             ? st_q.regs.min_duty2 : FAM_DUTY_ZERO;
        end
        if (st_q.regs.auto_mode && i_below_floor[2])
        begin
            st_d.out.duty3 = st_q.regs.acoustic2[FAM_FLOOR3_BIT]
                             ? st_q.regs.min_duty3 : FAM_DUTY_ZERO;
        end

        // Bus slave: one wait cycle, then acknowledge
        case (st_q.bus)
            ST_IDLE:
            begin
                if (i_avs_read || i_avs_write)
                begin
                    st_d.bus   = ST_ACK;
                    st_d.err   = 1'b0;
                    st_d.rdata = 32'h0;
                    if (hit_acou)
                    begin
                        st_d.rdata = {24'h0, st_q.regs.acoustic2};
                    end
                    else if (hit_cfg6)
                    begin
                        st_d.rdata = {24'h0, st_q.regs.config6};
                    end
                    else if (hit_lock)
                    begin
                        st_d.rdata = {31'h0, st_q.regs.locked};
                    end
                    else if (hit_fan)
                    begin
                        st_d.rdata = {7'h0, st_q.regs.auto_mode,
                                      st_q.regs.min_duty3,
                                      st_q.regs.min_duty2,
                                      st_q.regs.min_duty1};
                    end
                    else if (hit_stat)
                    begin
                        st_d.rdata = {8'h0, st_q.out.duty3, st_q.out.duty2,
                                      st_q.out.duty1};
                    end
                    else
                    begin
                        st_d.err = 1'b1;
                    end
                end
            end
            ST_ACK:
            begin
                st_d.bus = ST_DONE;
                // Writes land only on the edge where the master sees the
                // answer, so no setting moves before it is acknowledged
                if (i_avs_write && hit_lock && lo_en
                    && i_avs_writedata[FAM_LOCK_BIT])
                begin
                    // Lock is sticky until reset
                    st_d.regs.locked = 1'b1;
                end
                else if (i_avs_write && !st_q.regs.locked)
                begin
                    if (hit_acou && lo_en)
                    begin
                        st_d.regs.acoustic2 = i_avs_writedata[7:0];
                    end
                    else if (hit_cfg6 && lo_en)
                    begin
                        st_d.regs.config6 = i_avs_writedata[7:0];
                    end
                    else if (hit_fan)
                    begin
                        if (i_avs_byteenable[0])
                        begin
                            st_d.regs.min_duty1 = i_avs_writedata[7:0];
                        end
                        if (i_avs_byteenable[1])
                        begin
                            st_d.regs.min_duty2 = i_avs_writedata[15:8];
                        end
                        if (i_avs_byteenable[2])
                        begin
                            st_d.regs.min_duty3 = i_avs_writedata[23:16];
                        end
                        if (i_avs_byteenable[3])
                        begin
                            st_d.regs.auto_mode = i_avs_writedata[24];
                        end
                    end
                end
            end
            ST_DONE:
            begin
                st_d.bus = ST_IDLE;
            end
            default:
            begin
                // An illegal state code falls back to idle
                st_d.bus = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st_q                <= '0;
            st_q.bus            <= ST_IDLE;
            st_q.regs.acoustic2 <= FAM_RST_ACOUSTIC2;
            st_q.regs.config6   <= FAM_RST_CONFIG6;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Gated tach: tach 3 and 4 only valid while output 3 drives; tach 2 gated only while the sync bit is set
    always_comb
    begin
        o_tach_gated    = {1'b1, 1'b1,
                           st_q.regs.acoustic2[FAM_SYNC_BIT]};
        o_tach_valid[0] = !o_tach_gated[0] || drv3_on;
        o_tach_valid[1] = drv3_on;
        o_tach_valid[2] = drv3_on;
    end

    assign o_avs_waitrequest    = (st_q.bus != ST_ACK);
    assign o_avs_readdata       = st_q.rdata;
    assign o_avs_response       = st_q.err ? 2'b10 : 2'b00;
    assign o_fan_drive_output_1 = st_q.out.duty1;
    assign o_fan_drive_output_2 = st_q.out.duty2;
    assign o_fan_drive_output_3 = st_q.out.duty3;

endmodule : fam_ctrl

// ---- logic/fam_pkg.sv ----
// Package: register map, field layout and timing constants of the fan block
package fam_pkg;

    // Register map, byte addresses are four times the printed index
    localparam logic [7:0] FAM_IDX_ACOUSTIC2   = 8'h63;
    localparam logic [7:0] FAM_IDX_CONFIG6     = 8'h10;
    localparam logic [7:0] FAM_IDX_LOCK        = 8'h40;
    localparam logic [7:0] FAM_IDX_FAN_CTRL    = 8'h70;
    localparam logic [7:0] FAM_IDX_STATUS      = 8'h71;
    localparam logic [9:0] FAM_ADDR_ACOUSTIC2  = 10'h18c;
    localparam logic [9:0] FAM_ADDR_CONFIG6    = 10'h040;
    localparam logic [9:0] FAM_ADDR_LOCK       = 10'h100;
    localparam logic [9:0] FAM_ADDR_FAN_CTRL   = 10'h1c0;
    localparam logic [9:0] FAM_ADDR_STATUS     = 10'h1c4;

    // Reset values
    localparam logic [7:0] FAM_RST_ACOUSTIC2   = 8'h00;
    localparam logic [7:0] FAM_RST_CONFIG6     = 8'h00;
    localparam logic [7:0] FAM_RST_TARGET      = 8'h00;
    localparam logic [7:0] FAM_RST_MIN_DUTY    = 8'h00;

    // Field positions of the acoustic register
    localparam int FAM_RATE_LSB     = 0;
    localparam int FAM_SMOOTH_BIT   = 3;
    localparam int FAM_SYNC_BIT     = 4;
    localparam int FAM_FLOOR1_BIT   = 5;
    localparam int FAM_FLOOR2_BIT   = 6;
    localparam int FAM_FLOOR3_BIT   = 7;
    // Config register fields, and the lock register bit
    localparam int FAM_LONG_TABLE_BIT = 7;
    localparam int FAM_SLOW_R1_BIT    = 1;
    localparam int FAM_LOCK_BIT       = 0;

    // Ramp timing: a slot of the short table is 37.5 s / 255 steps
    localparam longint FAM_CLK_HZ        = 20000000;
    localparam longint FAM_SHORT_FULL_MS = 37500;
    localparam longint FAM_LONG_FULL_MS  = 52200;
    localparam longint FAM_DUTY_STEPS    = 255;
    localparam longint FAM_SHORT_SLOT_CYC =
        FAM_SHORT_FULL_MS * (FAM_CLK_HZ / 1000) / FAM_DUTY_STEPS;
    localparam longint FAM_LONG_SLOT_CYC =
        FAM_LONG_FULL_MS * (FAM_CLK_HZ / 1000) / FAM_DUTY_STEPS;
    localparam int FAM_SLOW_FACTOR = 4;
    localparam logic [7:0] FAM_DUTY_ZERO = 8'h00;

    typedef struct packed {
        logic [7:0] acoustic2;
        logic [7:0] config6;
        logic       locked;
        logic       auto_mode;
        logic [7:0] min_duty1;
        logic [7:0] min_duty2;
        logic [7:0] min_duty3;
    } fam_regs_t;

    typedef struct packed {
        logic [7:0] duty1;
        logic [7:0] duty2;
        logic [7:0] duty3;
    } fam_duty_t;

endpackage : fam_pkg

// ---- logic/fam_ramp.sv ----
// Slew limiter: moves a duty value toward its target one step per slot
`timescale 1ns/1ns
module fam_ramp
    import fam_pkg::*;
#(
    parameter longint SHORT_SLOT = FAM_SHORT_SLOT_CYC,
    parameter longint LONG_SLOT  = FAM_LONG_SLOT_CYC
)(
    input  wire logic       i_clock,
    input  wire logic       i_rstn,
    input  wire logic       i_smooth,
    input  wire logic       i_long_table,
    input  wire logic       i_slow,
    input  wire logic [2:0] i_rate,
    input  wire logic [7:0] i_target,
    output logic      [7:0] o_duty
);

    typedef struct packed {
        logic [31:0] slot_cnt;
        logic [7:0]  duty;
    } fam_ramp_st_t;

    fam_ramp_st_t st_q;
    fam_ramp_st_t st_d;
    logic [31:0]  slot_len;
    logic [7:0]   step;
    logic [8:0]   up_sum;

    // Step per slot from the three-bit rate code
    always_comb
    begin
        case (i_rate)
            3'h0: step = 8'h01;
            3'h1: step = 8'h02;
            3'h2: step = 8'h03;
            3'h3: step = 8'h04;
            3'h4: step = 8'h08;
            3'h5: step = 8'h0c;
            3'h6: step = 8'h18;
            default: step = 8'h30;
        endcase
    end

    always_comb
    begin
        slot_len = i_long_table ? 32'(LONG_SLOT) : 32'(SHORT_SLOT);
        if (i_slow)
        begin
            slot_len = 32'(slot_len * FAM_SLOW_FACTOR);
        end
        up_sum = {1'b0, st_q.duty} + {1'b0, step};
        st_d = st_q;
        if (!i_smooth)
        begin
            st_d.duty     = i_target;
            st_d.slot_cnt = 32'h0;
        end
        else if (st_q.duty == i_target)
        begin
            st_d.slot_cnt = 32'h0;
        end
        else if (st_q.slot_cnt + 32'h1 >= slot_len)
        begin
            // Clamp the last step so the ramp never overshoots
            st_d.slot_cnt = 32'h0;
            if (i_target > st_q.duty)
            begin
                st_d.duty = (up_sum > {1'b0, i_target}) ? i_target
                                                         : up_sum[7:0];
            end
            else
            begin
                st_d.duty = (st_q.duty - i_target < step) ? i_target
                                                          : st_q.duty - step;
            end
        end
        else
        begin
            st_d.slot_cnt = st_q.slot_cnt + 32'h1;
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign o_duty = st_q.duty;

endmodule : fam_ramp

// ---- tb/fam_ctrl_properties.sv ----
// Checker: bus answer, readback, tach gating and floor duty assertions
`timescale 1ns/1ns
module fam_ctrl_properties
    import fam_pkg::*;
(
    input wire logic        i_clock,
    input wire logic        i_rstn,
    input wire logic [9:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0]  i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic [1:0]  o_avs_response,
    input wire logic [2:0]  i_below_floor,
    input wire logic        i_fan_drive_output_3_on,
    input wire logic [7:0]  o_fan_drive_output_1,
    input wire logic [7:0]  o_fan_drive_output_2,
    input wire logic [7:0]  o_fan_drive_output_3,
    input wire logic [2:0]  o_tach_gated,
    input wire logic [2:0]  o_tach_valid
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    logic [7:0] acou_q;
    logic       lock_q;
    logic       auto_q;
    logic       done;
    logic       mapped;
    assign done = i_avs_write && !o_avs_waitrequest;
    assign mapped = i_avs_address inside {FAM_ADDR_ACOUSTIC2, FAM_ADDR_LOCK,
        FAM_ADDR_CONFIG6, FAM_ADDR_FAN_CTRL, FAM_ADDR_STATUS};
    // Shadow takes each acknowledged write at the edge the design does
    always_ff @(posedge i_clock or negedge i_rstn)
        if (!i_rstn)
        begin
            acou_q <= 8'h00;
            lock_q <= 1'b0;
            auto_q <= 1'b0;
        end
        else if (done)
        begin
            if (i_avs_address == FAM_ADDR_LOCK && i_avs_byteenable[0]
                && i_avs_writedata[FAM_LOCK_BIT])
                lock_q <= 1'b1;
            if (i_avs_address == FAM_ADDR_ACOUSTIC2 && !lock_q
                && i_avs_byteenable[0])
                acou_q <= i_avs_writedata[7:0];
            if (i_avs_address == FAM_ADDR_FAN_CTRL && !lock_q
                && i_avs_byteenable[3])
                auto_q <= i_avs_writedata[24];
        end
    AST_WAIT_ONE: assert property ($fell(o_avs_waitrequest)
        |=> o_avs_waitrequest) else $error("waitrequest low too long");
    AST_UNMAPPED: assert property (!o_avs_waitrequest && !mapped
        |-> o_avs_response == 2'b10) else $error("unmapped not refused");
    AST_READBACK: assert property (!o_avs_waitrequest && i_avs_read
        && i_avs_address == FAM_ADDR_ACOUSTIC2 |-> o_avs_readdata[7:0]
        == acou_q && o_avs_response == 2'b00) else $error("bad readback");
    AST_SYNC_BIT: assert property (
        o_tach_gated[0] == acou_q[FAM_SYNC_BIT]) else $error("sync bit");
    AST_TACH34: assert property (1'b1 |=> o_tach_gated[2:1] == 2'b11
        && o_tach_valid[1] == o_tach_valid[2]) else $error("tach 3 4");
    AST_FAN_TACH_INPUT_2_FREE: assert property (!o_tach_gated[0] ##1
        !o_tach_gated[0] |-> o_tach_valid[0]) else $error("tach 2 free");
    AST_FAN_TACH_INPUT_2_GATED: assert property (o_tach_gated[0]
        && $past(o_tach_gated[0]) |-> o_tach_valid[0] == o_tach_valid[2])
        else $error("tach 2 gated");
    AST_TACH_WINDOW: assert property (o_tach_valid[2]
        == $past(i_fan_drive_output_3_on, 2)) else $error("tach window");
    AST_FLOOR1_OFF: assert property (auto_q && !done
        && i_below_floor[0] && !acou_q[FAM_FLOOR1_BIT]
        |=> o_fan_drive_output_1 == FAM_DUTY_ZERO) else $error("out 1 on");
    AST_FLOOR2_OFF: assert property (auto_q && !done
        && i_below_floor[1] && !acou_q[FAM_FLOOR2_BIT]
        |=> o_fan_drive_output_2 == FAM_DUTY_ZERO) else $error("out 2 on");
    AST_FLOOR3_OFF: assert property (auto_q && !done
        && i_below_floor[2] && !acou_q[FAM_FLOOR3_BIT]
        |=> o_fan_drive_output_3 == FAM_DUTY_ZERO) else $error("out 3 on");
    cover property (done && i_avs_address == FAM_ADDR_LOCK);
    cover property (auto_q && i_below_floor[2] && acou_q[FAM_FLOOR3_BIT]);
    cover property ($rose(o_tach_gated[0]));
endmodule : fam_ctrl_properties

bind fam_ctrl fam_ctrl_properties u_chk (.*);

// ---- tb/fam_fan_model.sv ----
// Fan model: PWM pin wave from drive 3 and three tach pulse trains
`timescale 1ns/1ns
module fam_fan_model
    import fam_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_rstn,
    input  wire logic [7:0] i_duty,
    output logic            o_pin,
    output logic      [2:0] o_tach
);
    logic [7:0] phase_q;
    logic [7:0] spin_q;
    // A stopped fan gives no pulses, so tach only moves while driven
    always_ff @(posedge i_clock or negedge i_rstn)
        if (!i_rstn)
        begin
            phase_q <= 8'h00;
            spin_q  <= 8'h00;
        end
        else
        begin
            phase_q <= phase_q + 8'h01;
            spin_q  <= spin_q + {7'h00, o_pin};
        end
    assign o_pin  = phase_q < i_duty;
    assign o_tach = spin_q[5:3];
endmodule : fam_fan_model

// ---- tb/tb.sv ----
// Testbench: registers, ramp timing, floor duty and tach gating
`timescale 1ns/1ns
module tb;
    import fam_pkg::*;
    logic        i_clock, i_rstn, i_avs_read, i_avs_write;
    logic [9:0]  i_avs_address;
    logic [31:0] i_avs_writedata, o_avs_readdata, rdata;
    logic [3:0]  i_avs_byteenable;
    logic        o_avs_waitrequest, i_fan_drive_output_3_on;
    logic [1:0]  o_avs_response, rresp;
    logic [7:0]  i_target_duty1, i_target_duty2, i_target_duty3;
    logic [7:0]  o_fan_drive_output_1, o_fan_drive_output_2;
    logic [7:0]  o_fan_drive_output_3;
    logic [2:0]  i_below_floor, o_tach_gated, o_tach_valid;
    logic        i_fan_tach_input_2, i_fan_tach_input_3;
    logic        i_fan_tach_input_4;
    int          num_errors, comparisons;
    fam_ctrl #(.SHORT_SLOT(4), .LONG_SLOT(6)) u_dut (
        .i_clock, .i_rstn, .i_avs_address, .i_avs_read, .i_avs_write,
        .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
        .o_avs_waitrequest, .o_avs_response, .i_target_duty1,
        .i_target_duty2, .i_target_duty3, .i_below_floor,
        .i_fan_drive_output_3_on, .i_fan_tach_input_2,
        .i_fan_tach_input_3, .i_fan_tach_input_4,
        .o_fan_drive_output_1, .o_fan_drive_output_2,
        .o_fan_drive_output_3, .o_tach_gated, .o_tach_valid);
    fam_fan_model u_fan (.i_clock, .i_rstn, .i_duty(o_fan_drive_output_3),
        .o_pin(i_fan_drive_output_3_on), .o_tach({i_fan_tach_input_4,
        i_fan_tach_input_3, i_fan_tach_input_2}));
    task automatic chk(input string nm, input logic [31:0] exp, got);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Holds the request until waitrequest is low at a rising edge
    task automatic bus(input logic [9:0] a, input logic wr,
                       input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge i_clock);
        i_avs_address    <= a;
        i_avs_write      <= wr;
        i_avs_read       <= !wr;
        i_avs_writedata  <= d;
        i_avs_byteenable <= be;
        do @(posedge i_clock);
        while (o_avs_waitrequest !== 1'b0 && ++n < 40);
        chk("bus answer", 32'h0, o_avs_waitrequest);
        rdata = o_avs_readdata;
        rresp = o_avs_response;
        i_avs_read  <= 1'b0;
        i_avs_write <= 1'b0;
    endtask : bus
    task automatic test_regs;
        bus(FAM_ADDR_ACOUSTIC2, 1'b0, 32'h0, 4'hf);
        chk("acoustic reset", 8'h00, rdata[7:0]);
        bus(10'h3fc, 1'b0, 32'h0, 4'hf);
        chk("unmapped response", 2'b10, rresp);
        bus(FAM_ADDR_ACOUSTIC2, 1'b1, 32'h5a, 4'h1);
        bus(FAM_ADDR_ACOUSTIC2, 1'b0, 32'h0, 4'hf);
        chk("acoustic readback", 8'h5a, rdata[7:0]);
        $display("test_regs done");
    endtask : test_regs
    task automatic ramp_time(input logic [7:0] cfg, acou, input int lo, hi);
        int n;
        n = 0;
        bus(FAM_ADDR_ACOUSTIC2, 1'b1, 32'h0, 4'h1);
        i_target_duty1 <= 8'h00;
        repeat (4) @(negedge i_clock);
        chk("duty1 jump", 8'h00, o_fan_drive_output_1);
        bus(FAM_ADDR_CONFIG6, 1'b1, {24'h0, cfg}, 4'h1);
        bus(FAM_ADDR_ACOUSTIC2, 1'b1, {24'h0, acou}, 4'h1);
        i_target_duty1 <= 8'h60;
        do @(negedge i_clock);
        while (o_fan_drive_output_1 !== 8'h60 && ++n < 2000);
        chk("ramp cycles", 1'b1, n >= lo && n <= hi);
    endtask : ramp_time
    task automatic test_ramp;
        int step [8] = '{1, 2, 3, 4, 8, 12, 24, 48};
        int k;
        for (int c = 0; c < 8; c++)
        begin
            k = 96 / step[c];
            ramp_time(8'h00, 8'h08 | c[7:0], (k-1)*4, (k+1)*4+4);
        end
        ramp_time(8'h80, 8'h08, 95*6, 97*6+4);
        ramp_time(8'h02, 8'h08, 95*16, 97*16+4);
        $display("test_ramp done");
    endtask : test_ramp
    task automatic test_floor;
        @(posedge i_clock);
        i_target_duty2 <= 8'h80;
        i_target_duty3 <= 8'h80;
        bus(FAM_ADDR_CONFIG6, 1'b1, 32'h0, 4'h1);
        bus(FAM_ADDR_FAN_CTRL, 1'b1, 32'h0133_2211, 4'hf);
        bus(FAM_ADDR_ACOUSTIC2, 1'b1, 32'h00, 4'h1);
        i_below_floor <= 3'b111;
        repeat (3) @(negedge i_clock);
        chk("duty1 off", 8'h00, o_fan_drive_output_1);
        chk("duty2 off", 8'h00, o_fan_drive_output_2);
        chk("duty3 off", 8'h00, o_fan_drive_output_3);
        chk("tach gating", 3'b110, o_tach_gated);
        bus(FAM_ADDR_ACOUSTIC2, 1'b1, 32'hf0, 4'h1);
        repeat (3) @(negedge i_clock);
        chk("duty1 min", 8'h11, o_fan_drive_output_1);
        chk("duty2 min", 8'h22, o_fan_drive_output_2);
        chk("duty3 min", 8'h33, o_fan_drive_output_3);
        chk("tach gating", 3'b111, o_tach_gated);
        bus(FAM_ADDR_STATUS, 1'b0, 32'h0, 4'hf);
        chk("status duties", 32'h0033_2211, rdata);
        @(posedge i_clock);
        i_below_floor <= 3'b000;
        repeat (3) @(negedge i_clock);
        chk("duty2 follow", 8'h80, o_fan_drive_output_2);
        $display("test_floor done");
    endtask : test_floor
    task automatic test_lock;
        bus(FAM_ADDR_LOCK, 1'b1, 32'h1, 4'h1);
        bus(FAM_ADDR_ACOUSTIC2, 1'b1, 32'h0a, 4'h1);
        bus(FAM_ADDR_ACOUSTIC2, 1'b0, 32'h0, 4'hf);
        chk("locked acoustic", 8'hf0, rdata[7:0]);
        bus(FAM_ADDR_CONFIG6, 1'b1, 32'h82, 4'h1);
        bus(FAM_ADDR_CONFIG6, 1'b0, 32'h0, 4'hf);
        chk("locked config", 8'h00, rdata[7:0]);
        bus(FAM_ADDR_FAN_CTRL, 1'b1, 32'h0, 4'hf);
        bus(FAM_ADDR_FAN_CTRL, 1'b0, 32'h0, 4'hf);
        chk("locked fan ctrl", 32'h0133_2211, rdata);
        bus(FAM_ADDR_LOCK, 1'b0, 32'h0, 4'hf);
        chk("lock bit", 32'h1, rdata);
        $display("test_lock done");
    endtask : test_lock
    task automatic tally_and_finish;
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end
    // Whole run needs some 3300 cycles; 20000 leaves ample margin
    initial
    begin
        #1000000;
        num_errors++;
        tally_and_finish();
    end
    initial
    begin
        {num_errors, comparisons} = '0;
        {i_rstn, i_avs_read, i_avs_write, i_below_floor} = '0;
        {i_avs_address, i_avs_writedata, i_avs_byteenable} = '0;
        {i_target_duty1, i_target_duty2, i_target_duty3} = '0;
        repeat (6) @(posedge i_clock);
        i_rstn <= 1'b1;
        test_regs();
        test_ramp();
        test_floor();
        test_lock();
        tally_and_finish();
    end
endmodule : tb
